//--- hw/err_mon_pkg.sv
// shared constants, types and helpers of the channel error monitor
package err_mon_pkg;
    localparam int CLK_NS = 50;
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_min
    localparam int DWELL_LEAD_NS = 1000;
    localparam int PRE_DELAY1_NS = 2000;
    localparam int PRE_DELAY2_NS = 500;
    localparam int PHASE_TOL_NS  = 100;
    localparam logic [7:0] DWELL_LEAD_CYC = 8'(cyc_min(DWELL_LEAD_NS));
    localparam logic [7:0] PRE_DELAY1_CYC = 8'(cyc_min(PRE_DELAY1_NS));
    localparam logic [7:0] PRE_DELAY2_CYC = 8'(cyc_min(PRE_DELAY2_NS));
    localparam logic [7:0] PHASE_TOL_CYC  = 8'(cyc_min(PHASE_TOL_NS));
    localparam logic [7:0] TIMER_SAT      = 8'hFF;
    // link word: sync, parity, first-of-instruction, 13 data bits
    localparam int WORD_W = 16;
    localparam int W_SYNC = 15;
    localparam int W_PAR = 14;
    localparam int W_FIRST = 13;
    localparam int OP_HI = 12;
    localparam int OP_LO = 9;
    localparam int HI_W = 9;
    localparam int PAY_W = 22;
    localparam int FIFO_DEPTH = 8;
    localparam int AMP_W = 12;
    localparam int SCALE_W = 8;
    localparam int AMP_FRAC = 7;
    localparam logic [AMP_W-1:0] SCALE_RST = 12'h080;
    localparam logic [PAY_W-1:0] COARSE_MIN = 22'h000010;
    localparam logic [PAY_W-1:0] COARSE_MAX = 22'h000FF0;
    localparam logic [15:0] PARAM_MAX = 16'h0FFF;
    localparam logic [1:0] FEAT_ECL = 2'h2;
    localparam logic [1:0] NEWCMD_ECL = 2'h3;
    localparam logic [7:0] INFO_ERASED = 8'hFF;
    typedef enum logic [3:0] {OP_NOP, OP_GATE, OP_AMP_PRI, OP_AMP_SHIFT, OP_AMP_SCALE,
                              OP_FREQ, OP_OFFSET, OP_COARSE, OP_OBSERVE, OP_SCAN} rt_op_t;
    typedef enum logic [2:0] {G_IDLE, G_TX, G_ACQ, G_TUNE, G_HOMO} gate_t;
    localparam logic [2:0] GATE_LAST = 3'h4;
    typedef enum logic [3:0] {CMD_INIT, CMD_PARAM, CMD_FEAT, CMD_NEWCMD} cmd_t;
    localparam int E_BOARD = 0, E_PWR = 1, E_RANGE = 2, E_FUNC = 3, E_SYNTAX = 4, E_CMDHW = 5;
    localparam int E_BISC = 6, E_BISS = 7, E_PAR = 8, E_SYNC = 9, E_ALIGN = 10, E_DWELL = 11;
    localparam int E_PRE1 = 12, E_PRE2 = 13, E_TRANS = 14, E_UNK = 15, E_NCO = 16, E_SCAN = 17;
    localparam int E_OFS = 18, E_COARSE = 19, E_OBS = 20, E_AMP = 21, E_PHASE = 22, N_ERR = 23;
    localparam logic [6:0] ERR_CODE [N_ERR] = '{7'h05, 7'h0D, 7'h0F, 7'h11, 7'h14, 7'h15,
        7'h3A, 7'h3B, 7'h40, 7'h41, 7'h42, 7'h43, 7'h45, 7'h46, 7'h47, 7'h48, 7'h49, 7'h4A,
        7'h4B, 7'h4C, 7'h4D, 7'h4E, 7'h57};
    function automatic logic odd_par(input logic [WORD_W-1:0] w);
        return ^w;
    endfunction : odd_par
endpackage : err_mon_pkg

//--- hw/rt_link_if.sv
// link between sequencer/host end and the monitor end
`timescale 1ns/1ps
`default_nettype none
interface rt_link_if;
    import err_mon_pkg::*;
    logic              link_valid;
    logic [WORD_W-1:0] link_word;
    logic              link_ready;
    logic              cmd_valid;
    logic [3:0]        cmd_addr;
    logic [3:0]        cmd_dev_id;
    logic [3:0]        cmd_op;
    logic [15:0]       cmd_param;
    logic              err_valid;
    logic [6:0]        err_code;
    logic              err_ack;
    modport host_end (output link_valid, link_word, cmd_valid, cmd_addr, cmd_dev_id, cmd_op,
                      cmd_param, err_ack, input link_ready, err_valid, err_code);
    modport dev_end (input link_valid, link_word, cmd_valid, cmd_addr, cmd_dev_id, cmd_op,
                     cmd_param, err_ack, output link_ready, err_valid, err_code);
endinterface : rt_link_if
`default_nettype wire

//--- hw/err_mon_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module err_mon_fifo #(
    parameter int W = 16,
    parameter int D = 8
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_reset_n,
    input  wire logic         i_in_valid,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_in_ready,
    output logic              o_out_valid,
    output logic [W-1:0]      o_out_data,
    input  wire logic         i_out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;
    assign o_in_ready = (cnt_q != (AW+1)'(D));
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data = mem_q[rd_q];
    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
            if (pop) rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : err_mon_fifo
`default_nettype wire

//--- hw/err_mon_dev.sv
// channel error monitor: checks link, commands, gating and datapath, reports codes
// Overview of operation
// [R01] board address differs from command id: 5
// [R02] report 13 after power-up until read
// [R03] out-of-range command parameter rejected: 15
// [R04] unsupported function 17, unavailable command 21
// [R05] unknown command gives syntax error 20
// [R06] info store corrupt 58, checksum 59
// [R07] link word parity mismatch gives 64
// [R08] wrong link sync bit gives 65
// [R09] instruction boundary misalignment gives 66
// [R10] dwell lead too short at acquisition: 67
// [R11] tune entry pre-delay 1 short: 69
// [R12] homo entry pre-delay 2 short: 70
// [R13] disallowed gating transition gives 71
// [R14] unknown real-time instruction gives 72
// [R15] primary plus shift amplitude overflow: 73
// [R16] scan info overrun before forwarding: 74
// [R17] frequency plus offset overflow: 75
// [R18] coarse frequency out of range: 76
// [R19] both channels observe gives 77
// [R20] amplitude combining stage overflow gives 78
// [R21] sync clock phase off reference: 87
// [R22] sequencer sends instructions at 12.5ns resolution; here one link word per 50ns clock, two words per instruction
// [R23] steady yellow while error pending
// [R24] errors latched with code until read
`timescale 1ns/1ps
`default_nettype none
module err_mon_dev
    import err_mon_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset_n,
    rt_link_if.dev_end       lnk,
    input  wire logic [1:0]  i_engineering_change_level,
    input  wire logic        i_info_valid,
    input  wire logic [7:0]  i_info_byte,
    input  wire logic        i_info_last,
    input  wire logic        i_backplane_sync_clock,
    input  wire logic        i_ref_mark,
    input  wire logic        i_scan_ready,
    output logic             o_scan_valid,
    output logic [PAY_W-1:0] o_scan_data,
    output logic [1:0]       o_observe,
    output logic [2:0]       o_gating_state,
    output logic             o_status_yellow
);
    logic [WORD_W-1:0] w;
    logic              f_valid;
    logic              busy_q;
    logic              take;
    logic              good;
    logic              exp2_q;
    rt_op_t            op_q;
    logic [HI_W-1:0]   hi_q;
    logic              exec;
    logic [PAY_W-1:0]  pay;
    gate_t             gate_q;
    gate_t             gate_d;
    logic              gate_go;
    logic [7:0]        since_tx_q;
    logic [7:0]        since_tune_q;
    logic [AMP_W-1:0]  pri_q;
    logic [AMP_W-1:0]  shf_q;
    logic [SCALE_W-1:0] scl_q;
    logic [AMP_W-1:0]  pri_d;
    logic [AMP_W-1:0]  shf_d;
    logic [SCALE_W-1:0] scl_d;
    logic              amp_go;
    logic signed [PAY_W-1:0] frq_q;
    logic signed [PAY_W-1:0] ofs_q;
    logic signed [PAY_W-1:0] frq_d;
    logic signed [PAY_W-1:0] ofs_d;
    logic              frq_go;
    logic [PAY_W-1:0]  coarse_q;
    logic [1:0]        obs_d;
    logic              obs_go;
    logic [7:0]        sum_q;
    logic [7:0]        sum_n;
    logic              sync_d1_q;
    logic [7:0]        since_sync_q;
    logic [N_ERR-1:0]  ev;
    logic [N_ERR-1:0]  pend_q;
    logic [4:0]        sel_q;
    logic              rep_q;
    logic [6:0]        code_q;

    function automatic logic gate_ok(input gate_t c, input gate_t n);
        unique case (c)
            G_IDLE:  return 1'b1;
            G_TX:    return n != G_TUNE;
            G_ACQ:   return n == G_IDLE || n == G_TX;
            G_TUNE:  return n == G_IDLE || n == G_TUNE;
            G_HOMO:  return n != G_TUNE;
            default: return 1'b0;
        endcase
    endfunction : gate_ok

    function automatic logic amp_ovf(input logic [AMP_W-1:0] a, input logic [AMP_W-1:0] b,
                                     input logic [SCALE_W-1:0] s, output logic sum_ovf);
        logic [AMP_W:0]           sum;
        logic [AMP_W+SCALE_W-1:0] prod;
        sum = {1'b0, a} + {1'b0, b};
        sum_ovf = sum[AMP_W];
        prod = sum[AMP_W-1:0] * s;
        return prod[AMP_W+SCALE_W-1 -: (SCALE_W-AMP_FRAC)] != '0;
    endfunction : amp_ovf

    function automatic logic [4:0] lowest(input logic [N_ERR-1:0] v);
        logic [4:0] r;
        r = '0;
        for (int i = N_ERR - 1; i >= 0; i--) begin
            if (v[i]) r = 5'(i);
        end
        return r;
    endfunction : lowest

    err_mon_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_reset_n   (i_reset_n),
        .i_in_valid  (lnk.link_valid),
        .i_in_data   (lnk.link_word),
        .o_in_ready  (lnk.link_ready),
        .o_out_valid (f_valid),
        .o_out_data  (w),
        .i_out_ready (!busy_q)
    );

    assign take = f_valid & ~busy_q;
    assign good = take & !odd_par(w) & w[W_SYNC];
    assign exec = good & !w[W_FIRST] & exp2_q;
    assign pay = {hi_q, w[OP_HI:0]};
    assign sum_n = sum_q + i_info_byte;

    // the decoder takes a word every other cycle, so a dense burst backs up the fifo
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            busy_q <= 1'b0;
            exp2_q <= 1'b0;
            op_q <= OP_NOP;
            hi_q <= '0;
        end else begin
            busy_q <= take;
            if (good && w[W_FIRST]) begin
                exp2_q <= 1'b1;
                op_q <= rt_op_t'(w[OP_HI:OP_LO]);
                hi_q <= w[HI_W-1:0];
            end else if (good) begin
                exp2_q <= 1'b0;
            end
        end
    end

    always_comb begin
        ev = '0;
        gate_d = gate_t'(pay[2:0]);
        gate_go = 1'b0;
        pri_d = pri_q;
        shf_d = shf_q;
        scl_d = scl_q;
        amp_go = 1'b0;
        frq_d = frq_q;
        ofs_d = ofs_q;
        frq_go = 1'b0;
        obs_d = o_observe;
        obs_go = 1'b0;
        ev[E_PAR] = take & odd_par(w); // see [R07]
        ev[E_SYNC] = take & !w[W_SYNC]; // see [R08]
        ev[E_ALIGN] = good & (w[W_FIRST] == exp2_q); // see [R09]
        if (exec) begin
            unique case (op_q)
                OP_NOP: ;
                OP_GATE: begin
                    if (pay[2:0] > GATE_LAST || !gate_ok(gate_q, gate_d)) begin
                        ev[E_TRANS] = 1'b1; // see [R13]
                    end else begin
                        gate_go = 1'b1;
                        ev[E_DWELL] = gate_q == G_TX && gate_d == G_ACQ
                                      && since_tx_q < DWELL_LEAD_CYC; // see [R10]
                        ev[E_PRE1] = gate_q != G_TUNE && gate_d == G_TUNE
                                     && since_tune_q < PRE_DELAY1_CYC; // see [R11]
                        ev[E_PRE2] = gate_q != G_HOMO && gate_d == G_HOMO
                                     && since_tx_q < PRE_DELAY2_CYC; // see [R12]
                    end
                end
                OP_AMP_PRI: begin
                    pri_d = pay[AMP_W-1:0];
                    amp_go = 1'b1;
                end
                OP_AMP_SHIFT: begin
                    shf_d = pay[AMP_W-1:0];
                    amp_go = 1'b1;
                end
                OP_AMP_SCALE: begin
                    scl_d = pay[SCALE_W-1:0];
                    amp_go = 1'b1;
                end
                OP_FREQ: begin
                    frq_d = pay;
                    frq_go = 1'b1;
                end
                OP_OFFSET: begin
                    ofs_d = pay;
                    frq_go = 1'b1;
                end
                OP_COARSE: ev[E_COARSE] = pay < COARSE_MIN || pay > COARSE_MAX; // see [R18]
                OP_OBSERVE: begin
                    obs_d[pay[0]] = pay[1];
                    ev[E_OBS] = &obs_d; // see [R19]
                    obs_go = !ev[E_OBS];
                end
                OP_SCAN: ev[E_SCAN] = o_scan_valid & !i_scan_ready; // see [R16]
                default: ev[E_UNK] = 1'b1; // see [R14]
            endcase
        end
        if (amp_go) begin
            ev[E_AMP] = amp_ovf(pri_d, shf_d, scl_d, ev[E_NCO]); // see [R15] see [R20]
            amp_go = !ev[E_AMP] && !ev[E_NCO];
        end
        if (frq_go) begin
            ev[E_OFS] = (frq_d[PAY_W-1] == ofs_d[PAY_W-1])
                        && (PAY_W'(frq_d + ofs_d) >> (PAY_W-1)) != PAY_W'(frq_d[PAY_W-1]); // see [R17]
        end
        if (lnk.cmd_valid) begin
            if (lnk.cmd_addr != lnk.cmd_dev_id) begin
                ev[E_BOARD] = 1'b1; // see [R01]
            end else begin
                unique case (lnk.cmd_op)
                    CMD_INIT: ;
                    CMD_PARAM: ev[E_RANGE] = lnk.cmd_param > PARAM_MAX; // see [R03]
                    CMD_FEAT: ev[E_FUNC] = i_engineering_change_level < FEAT_ECL; // see [R04]
                    CMD_NEWCMD: ev[E_CMDHW] = i_engineering_change_level < NEWCMD_ECL; // see [R04]
                    default: ev[E_SYNTAX] = 1'b1; // see [R05]
                endcase
            end
        end
        ev[E_BISC] = i_info_valid & (i_info_byte == INFO_ERASED); // see [R06]
        ev[E_BISS] = i_info_valid & i_info_last & (sum_n != '0); // see [R06]
        ev[E_PHASE] = i_ref_mark & (since_sync_q > PHASE_TOL_CYC); // see [R21]
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            gate_q <= G_IDLE;
            since_tx_q <= TIMER_SAT;
            since_tune_q <= TIMER_SAT;
        end else begin
            if (gate_go) gate_q <= gate_d;
            if (gate_q == G_TX) since_tx_q <= '0;
            else if (since_tx_q != TIMER_SAT) since_tx_q <= since_tx_q + 1'b1;
            if (gate_q == G_TUNE) since_tune_q <= '0;
            else if (since_tune_q != TIMER_SAT) since_tune_q <= since_tune_q + 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            pri_q <= '0;
            shf_q <= '0;
            scl_q <= SCALE_RST[SCALE_W-1:0];
            frq_q <= '0;
            ofs_q <= '0;
            coarse_q <= COARSE_MIN;
            o_observe <= '0;
        end else begin
            if (amp_go) begin
                pri_q <= pri_d;
                shf_q <= shf_d;
                scl_q <= scl_d;
            end
            if (frq_go && !ev[E_OFS]) begin
                frq_q <= frq_d;
                ofs_q <= ofs_d;
            end
            if (exec && op_q == OP_COARSE && !ev[E_COARSE]) coarse_q <= pay;
            if (obs_go) o_observe <= obs_d;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            o_scan_valid <= 1'b0;
            o_scan_data <= '0;
        end else if (exec && op_q == OP_SCAN && !ev[E_SCAN]) begin
            o_scan_valid <= 1'b1;
            o_scan_data <= pay;
        end else if (i_scan_ready) begin
            o_scan_valid <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            sum_q <= '0;
            sync_d1_q <= 1'b0;
            since_sync_q <= TIMER_SAT;
        end else begin
            if (i_info_valid) sum_q <= i_info_last ? '0 : sum_n;
            sync_d1_q <= i_backplane_sync_clock;
            if (i_backplane_sync_clock && !sync_d1_q) since_sync_q <= '0;
            else if (since_sync_q != TIMER_SAT) since_sync_q <= since_sync_q + 1'b1;
        end
    end

    // pending errors stay until the host acknowledges the reported code; new events win
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            pend_q <= N_ERR'(1) << E_PWR; // see [R02]
            rep_q <= 1'b0;
            sel_q <= '0;
            code_q <= '0;
            o_status_yellow <= 1'b0;
        end else begin
            pend_q <= (pend_q & ~((N_ERR'(rep_q & lnk.err_ack)) << sel_q)) | ev; // see [R24]
            o_status_yellow <= |pend_q; // see [R23]
            if (rep_q && lnk.err_ack) begin
                rep_q <= 1'b0;
            end else if (!rep_q && |pend_q) begin
                rep_q <= 1'b1;
                sel_q <= lowest(pend_q);
                code_q <= ERR_CODE[lowest(pend_q)]; // see [R24]
            end
        end
    end

    assign lnk.err_valid = rep_q;
    assign lnk.err_code = code_q;
    assign o_gating_state = gate_q;
endmodule : err_mon_dev
`default_nettype wire

//--- hw/err_mon_host.sv
// sequencer and host end: sends instruction words and commands, collects error codes
`timescale 1ns/1ps
`default_nettype none
module err_mon_host
    import err_mon_pkg::*;
(
    input  wire logic             i_ref_clk,
    input  wire logic             i_reset_n,
    rt_link_if.host_end           lnk,
    input  wire logic             i_instr_valid,
    input  wire logic [3:0]       i_instr_opcode,
    input  wire logic [PAY_W-1:0] i_instr_payload,
    output logic                  o_instr_ready,
    input  wire logic             i_cmd_valid,
    input  wire logic [3:0]       i_cmd_addr,
    input  wire logic [3:0]       i_cmd_dev_id,
    input  wire logic [3:0]       i_cmd_op,
    input  wire logic [15:0]      i_cmd_param,
    output logic                  o_err_valid,
    output logic [6:0]            o_err_code,
    input  wire logic             i_err_taken
);
    logic [WORD_W-1:0] word_q;
    logic              lv_q;
    logic              second_q;
    logic [OP_HI:0]    lo_q;
    logic              ack_q;

    function automatic logic [WORD_W-1:0] mk_word(input logic first, input logic [OP_HI:0] d);
        logic [WORD_W-1:0] r;
        r = {1'b1, 1'b0, first, d};
        r[W_PAR] = odd_par(r);
        return r;
    endfunction : mk_word

    // one word per clock at most; the monitor's fifo throttles through link_ready
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            lv_q <= 1'b0;
            word_q <= '0;
            second_q <= 1'b0;
            lo_q <= '0;
            o_instr_ready <= 1'b1;
        end else if (lv_q && !lnk.link_ready) begin
            o_instr_ready <= 1'b0;
        end else if (second_q) begin
            lv_q <= 1'b1;
            word_q <= mk_word(1'b0, lo_q);
            second_q <= 1'b0;
            o_instr_ready <= 1'b1;
        end else if (i_instr_valid && o_instr_ready) begin
            lv_q <= 1'b1;
            word_q <= mk_word(1'b1, {i_instr_opcode, i_instr_payload[PAY_W-1 -: HI_W]});
            lo_q <= i_instr_payload[OP_HI:0];
            second_q <= 1'b1;
            o_instr_ready <= 1'b0;
        end else begin
            lv_q <= 1'b0;
            o_instr_ready <= 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            lnk.cmd_valid <= 1'b0;
            lnk.cmd_addr <= '0;
            lnk.cmd_dev_id <= '0;
            lnk.cmd_op <= '0;
            lnk.cmd_param <= '0;
        end else begin
            lnk.cmd_valid <= i_cmd_valid;
            if (i_cmd_valid) begin
                lnk.cmd_addr <= i_cmd_addr;
                lnk.cmd_dev_id <= i_cmd_dev_id;
                lnk.cmd_op <= i_cmd_op;
                lnk.cmd_param <= i_cmd_param;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            ack_q <= 1'b0;
            o_err_valid <= 1'b0;
            o_err_code <= '0;
        end else begin
            ack_q <= 1'b0;
            if (lnk.err_valid && !ack_q && (!o_err_valid || i_err_taken)) begin
                o_err_valid <= 1'b1;
                o_err_code <= lnk.err_code;
                ack_q <= 1'b1;
            end else if (i_err_taken) begin
                o_err_valid <= 1'b0;
            end
        end
    end

    assign lnk.link_valid = lv_q;
    assign lnk.link_word = word_q;
    assign lnk.err_ack = ack_q;
endmodule : err_mon_host
`default_nettype wire

//--- verif/channel_error_monitor_checker.sv
// assertions on the link between the sequencer end and the monitor end
`timescale 1ns/1ps
`default_nettype none
module channel_error_monitor_checker (
    input wire logic        i_ref_clk,
    input wire logic        i_reset_n,
    input wire logic        link_valid,
    input wire logic [15:0] link_word,
    input wire logic        link_ready,
    input wire logic        err_valid,
    input wire logic [6:0]  err_code,
    input wire logic        err_ack
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    AST_PAR_EVEN: assert property (link_valid |-> !(^link_word))
        else $error("link word with odd parity");
    AST_SYNC_SET: assert property (link_valid |-> link_word[15])
        else $error("link word without sync bit");
    AST_WORD_HOLD: assert property (link_valid && !link_ready |=> link_valid && $stable(link_word))
        else $error("link word dropped while refused");
    AST_FIRST_SECOND: assert property (link_valid && link_ready && link_word[13] |=> link_valid && !link_word[13])
        else $error("second word missing after first");
    AST_ERR_HOLD: assert property (err_valid && !err_ack |=> err_valid && $stable(err_code))
        else $error("error code not held until read");
    AST_ERR_CLEAR: assert property (err_valid && err_ack |=> !err_valid)
        else $error("error offer not removed after read");
    AST_ACK_ONLY: assert property (err_ack |-> err_valid)
        else $error("read without offered error");
    AST_PWR_CODE: assert property ($rose(i_reset_n) |-> ##[0:2] err_valid && err_code == 7'h0D)
        else $error("power-up code not offered");
endmodule : channel_error_monitor_checker
`default_nettype wire

//--- verif/tb_channel_error_monitor.sv
// bench: both ends joined, plus a second monitor fed by a rule-breaking driver
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; $display("wrong value %0t: %h", $time, a); end end
module tb_channel_error_monitor;
    import err_mon_pkg::*;
    logic             clk, rst_n, iv, cv, tk, fv, fl, sy, rm, sr, ir, ev, full_q;
    logic [3:0]       op, ca, cd, co;
    logic [PAY_W-1:0] pl;
    logic [15:0]      cp;
    logic [1:0]       engineering_change_level, s_v, yel;
    logic [7:0]       fb;
    logic [6:0]       ec;
    logic [PAY_W-1:0] s_d [2];
    logic [1:0]       obs [2];
    logic [2:0]       gs [2];
    int               error_cnt = 0, checks_done = 0, cyc = 0;
    rt_link_if lnk [2] ();
    err_mon_host u_err_mon_host (.i_ref_clk(clk), .i_reset_n(rst_n), .lnk(lnk[0]), .i_instr_valid(iv),
        .i_instr_opcode(op), .i_instr_payload(pl), .o_instr_ready(ir), .i_cmd_valid(cv), .i_cmd_addr(ca),
        .i_cmd_dev_id(cd), .i_cmd_op(co), .i_cmd_param(cp), .o_err_valid(ev), .o_err_code(ec), .i_err_taken(tk));
    for (genvar g = 0; g < 2; g++) begin : g_dev
        err_mon_dev u_err_mon_dev (.i_ref_clk(clk), .i_reset_n(rst_n), .lnk(lnk[g]), .i_engineering_change_level(engineering_change_level),
            .i_info_valid(fv), .i_info_byte(fb), .i_info_last(fl), .i_backplane_sync_clock(sy), .i_ref_mark(rm),
            .i_scan_ready(sr), .o_scan_valid(s_v[g]), .o_scan_data(s_d[g]), .o_observe(obs[g]),
            .o_gating_state(gs[g]), .o_status_yellow(yel[g]));
    end
    channel_error_monitor_checker u_channel_error_monitor_checker (.i_ref_clk(clk), .i_reset_n(rst_n),
        .link_valid(lnk[0].link_valid), .link_word(lnk[0].link_word), .link_ready(lnk[0].link_ready),
        .err_valid(lnk[0].err_valid), .err_code(lnk[0].err_code), .err_ack(lnk[0].err_ack));
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        full_q <= rst_n & (full_q | !lnk[0].link_ready);
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim
    task automatic st(int n = 1);
        repeat (n) @(posedge clk);
        #2;
    endtask : st
    task automatic ins(int o, int p);
        iv = 1;
        op = o[3:0];
        pl = p[PAY_W-1:0];
        st();
        while (ir !== 1'b1) st();
        iv = 0;
        st();
    endtask : ins
    task automatic cmd(int d, int o, int p);
        cv = 1;
        ca = 4'h3;
        cd = d[3:0];
        co = o[3:0];
        cp = p[15:0];
        st();
        cv = 0;
        st();
    endtask : cmd
    task automatic info(int b, bit l);
        fv = 1;
        fb = b[7:0];
        fl = l;
        st();
        fv = 0;
        st();
    endtask : info
    task automatic wb(bit s, bit f, bit bad);
        lnk[1].link_valid = 1;
        lnk[1].link_word = {s, s ^ f ^ bad, f, 13'h0};
        st();
        lnk[1].link_valid = 0;
        st();
    endtask : wb
    task automatic rd(bit b, int x);
        int n = 0;
        while ((b ? lnk[1].err_valid : ev) !== 1'b1 && n < 40) begin
            st();
            n++;
        end
        `CK(b ? {lnk[1].err_valid, lnk[1].err_code} : {ev, ec}, {1'b1, x[6:0]})
        lnk[1].err_ack = b;
        tk = !b;
        st();
        lnk[1].err_ack = 0;
        tk = 0;
        st();
    endtask : rd
    task automatic nil(string s);
        st(20);
        `CK({ev, yel[0]}, 2'b00)
        $display("test %s done", s);
    endtask : nil
    initial begin
        {iv, cv, tk, fv, fl, sy, rm, op, ca, cd, co, pl, cp, fb} = '0;
        {lnk[1].link_valid, lnk[1].link_word, lnk[1].cmd_valid, lnk[1].cmd_addr, lnk[1].err_ack} = '0;
        {lnk[1].cmd_dev_id, lnk[1].cmd_op, lnk[1].cmd_param} = '0;
        {sr, engineering_change_level, rst_n} = 4'h2;
        st(6);
        rst_n = 1;
        st(2);
        `CK(yel, 2'b11)
        rd(1, 'h0D);
        wb(1, 1, 1);
        rd(1, 'h40);
        wb(0, 1, 0);
        rd(1, 'h41);
        wb(1, 0, 0);
        rd(1, 'h42);
        rd(0, 'h0D);
        nil("link");
        cmd(5, 0, 0);
        cmd(3, 4, 0);
        rd(0, 'h05);
        rd(0, 'h14);
        cmd(3, 1, 'h1000);
        rd(0, 'h0F);
        cmd(3, 1, 'h0FFF);
        cmd(3, 2, 0);
        rd(0, 'h11);
        cmd(3, 3, 0);
        rd(0, 'h15);
        engineering_change_level = 2'h3;
        cmd(3, 2, 0);
        cmd(3, 3, 0);
        info('hFF, 0);
        info(1, 1);
        rd(0, 'h3A);
        info(1, 1);
        rd(0, 'h3B);
        nil("commands");
        ins(1, 1);
        ins(1, 2);
        rd(0, 'h43);
        ins(1, 3);
        rd(0, 'h47);
        `CK(gs[0], 3'h2)
        ins(1, 0);
        ins(1, 3);
        ins(1, 0);
        ins(1, 3);
        rd(0, 'h45);
        ins(1, 0);
        ins(1, 1);
        ins(1, 4);
        rd(0, 'h46);
        `CK(gs[0], 3'h4)
        for (int k = 10; k < 16; k++) begin
            ins(k, 0);
            rd(0, 'h48);
        end
        nil("gating");
        ins(2, 'hFFF);
        ins(3, 1);
        rd(0, 'h49);
        ins(4, 'h81);
        rd(0, 'h4E);
        ins(5, 'h1FFFFF);
        ins(6, 1);
        rd(0, 'h4B);
        ins(7, 'hF);
        rd(0, 'h4C);
        ins(7, 'h10);
        ins(8, 2);
        ins(8, 3);
        rd(0, 'h4D);
        `CK(obs[0], 2'b01)
        sr = 0;
        ins(9, 'h55);
        ins(9, 1);
        rd(0, 'h4A);
        `CK({s_v[0], s_d[0]}, {1'b1, 22'h55})
        sr = 1;
        sy = 1;
        st();
        rm = 1;
        st();
        {rm, sy} = 2'b00;
        nil("datapath");
        st(6);
        rm = 1;
        st();
        rm = 0;
        rd(0, 'h57);
        iv = 1;
        op = 4'h0;
        st(90);
        iv = 0;
        `CK(full_q, 1'b1)
        nil("stall");
        end_sim();
    end
endmodule : tb_channel_error_monitor
`default_nettype wire
